// ### verilog/mei_encoder_if.v
// Function
// R01: reset selects back-EMF decoder; source bit 1 enables quadrature inputs.
// R02: back-EMF decoder runs only at standstill with freewheel option 1 or 2.
// R03: host sets hold current to 0; decoding waits for actual scale zero.
// R04: host sets chopper off time 0 so the bridge freewheels.
// R05: quiescence keeps back-EMF decoding when source 0 and quiescence enable 1.
// R06: decoding starts after blank field times 2^14 cycles of standstill.
// R07: 3-bit threshold select picks comparator hysteresis 10 to 250 mV.
// R08: standstill flag after programmable time, default 2^20 cycles.
// R09: 2-bit filter select divides clock by 24600, 12300, 6150 or 2870.
// R10: encoder counter writable for preset and readable at any time.
// R11: each A/B transition adds or subtracts the encoder constant.
// R12: constant is signed 16.16, or integer plus 0..9999 in decimal mode.
// R13: host encodes negative decimal constants as 2^16-(int+1) and 10000-digits.
// R14: valid index clears the counter or latches the motor position.
// R15: continuous flag acts every index; single-shot acts once then clears.
// R16: index latch resets to 0 and captures encoder count every index.
// R17: index accepted only while A and B equal the polarity gate bits.
// R18: index clears counter only with clear bit and an action flag set.
// R19: index clears are recorded in status and drive the diagnostic pin.
// R20: back-EMF decoder counts whole full steps scaled by the constant.
// R21: A leading B counts up, B leading A counts down.
// R22: decimal fraction carries above 9999 and borrows below 0.
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "mei_defs.vh"

module mei_encoder_if #(
  parameter [31:0] BLANK_UNIT   = `MEI_BLANK_UNIT,
  parameter [23:0] STST_DEFAULT = `MEI_STST_DEFAULT,
  parameter [14:0] FILT_DIV0    = `MEI_FILT_DIV0,
  parameter [14:0] FILT_DIV1    = `MEI_FILT_DIV1,
  parameter [14:0] FILT_DIV2    = `MEI_FILT_DIV2,
  parameter [14:0] FILT_DIV3    = `MEI_FILT_DIV3
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // motor coil comparators and external encoder
  input  wire        bemf_cmp_a,
  input  wire        bemf_cmp_b,
  input  wire        enc_a,
  input  wire        enc_b,
  input  wire        enc_n,
  // motion and power state from the rest of the axis
  input  wire        motor_step,
  input  wire [31:0] x_actual,
  input  wire        cur_scale_zero,
  input  wire        quiescence_mode,
  // outputs
  output wire [2:0]  bemf_threshold_select,
  output reg         bemf_active,
  output reg         standstill,
  output reg         diagnostic_output_zero
);

  // configuration, counters and snapshots
  reg  [31:0] cfg_q;
  reg  [31:0] enc_const_q;
  reg  [31:0] x_enc_q;
  reg  [15:0] enc_frac_q;
  reg  [31:0] enc_latch_q;
  reg  [31:0] xact_latch_q;
  reg         clr_flag_q;
  reg  [1:0]  freewheel_q;
  reg  [23:0] stst_time_q;
  reg  [23:0] stst_cnt_q;
  reg  [31:0] blank_cnt_q;
  reg         n_q;
  reg  [31:0] rd_mux;
  // step pulses from the shared decoder
  wire        cnt_up;
  wire        cnt_dn;

  // address decode shared by read and write paths
  function reg_hit;
    input [11:0] a;
    begin
      case (a)
        `MEI_ADDR_ENCODER_MODE_CONFIG, `MEI_ADDR_ENC_CONST, `MEI_ADDR_X_ENC,
        `MEI_ADDR_ENC_LATCH, `MEI_ADDR_XACT_LATCH, `MEI_ADDR_ENC_STATUS,
        `MEI_ADDR_AXIS_CTRL, `MEI_ADDR_STST_TIME, `MEI_ADDR_AXIS_STAT:
                 reg_hit = 1'b1;
        default: reg_hit = 1'b0;
      endcase
    end
  endfunction

  // one encoder step on {integer, fraction}; decimal mode wraps the fraction at 10000
  function [47:0] step_pos;
    input [47:0] pos;
    input [31:0] k;
    input        dn;
    input        dec;
    reg   [16:0] f;
    reg   [31:0] i;
    reg   [31:0] ki;
    reg          cy;
    begin
      ki = {{16{k[31]}}, k[31:16]};
      f  = 17'h0_0000;
      i  = 32'h0000_0000;
      cy = 1'b0;
      // binary mode: one 48-bit add of the sign-extended constant
      if (!dec) begin
        step_pos = dn ? pos - {{16{k[31]}}, k} : pos + {{16{k[31]}}, k}; // R12
      end else begin
        // decimal mode: fraction and integer parts step separately
        if (dn) begin
          f  = {1'b0, pos[15:0]} - {1'b0, k[15:0]};
          cy = f[16];
          if (cy)
            f = f + `MEI_DEC_BASE; // R22
          i = pos[47:16] - ki - {31'h0000_0000, cy};
        end else begin
          f  = {1'b0, pos[15:0]} + {1'b0, k[15:0]};
          cy = (f >= `MEI_DEC_BASE);
          if (cy)
            f = f - `MEI_DEC_BASE; // R22
          i = pos[47:16] + ki + {31'h0000_0000, cy};
        end
        step_pos = {i, f[15:0]}; // R12
      end
    end
  endfunction

  // configuration fields
  wire        src_abn   = cfg_q[`MEI_F_SRC];
  wire        clr_cont  = cfg_q[`MEI_F_CLR_CONT];
  wire        clr_once  = cfg_q[`MEI_F_CLR_ONCE];
  wire        clr_enc   = cfg_q[`MEI_F_CLR_ENC];
  wire        dec_mode  = cfg_q[`MEI_F_DECIMAL];
  wire [7:0]  blank_fld = cfg_q[`MEI_F_BLANK_HI:`MEI_F_BLANK_LO];

  // comparator threshold goes straight out of the configuration flops
  // the analog comparator decodes the code; this block only holds it
  assign bemf_threshold_select = cfg_q[`MEI_F_HYST_HI:`MEI_F_HYST_LO]; // R07

  // apb handshake: one wait cycle, then pready for exactly one cycle
  wire acc_phase = psel & penable;
  wire wr_en     = acc_phase & pready & pwrite & reg_hit(paddr);

  // one strobe per writable register, all on the completing edge
  wire wr_cfg    = wr_en & (paddr == `MEI_ADDR_ENCODER_MODE_CONFIG);
  wire wr_const  = wr_en & (paddr == `MEI_ADDR_ENC_CONST);
  wire wr_xenc   = wr_en & (paddr == `MEI_ADDR_X_ENC);
  wire wr_status = wr_en & (paddr == `MEI_ADDR_ENC_STATUS);
  wire wr_ctrl   = wr_en & (paddr == `MEI_ADDR_AXIS_CTRL);
  wire wr_stst   = wr_en & (paddr == `MEI_ADDR_STST_TIME);

  // read multiplexer
  always @* begin
    case (paddr)
      `MEI_ADDR_ENCODER_MODE_CONFIG:    rd_mux = cfg_q;
      `MEI_ADDR_ENC_CONST:  rd_mux = enc_const_q;
      `MEI_ADDR_X_ENC:      rd_mux = x_enc_q; // R10
      `MEI_ADDR_ENC_LATCH:  rd_mux = enc_latch_q;
      `MEI_ADDR_XACT_LATCH: rd_mux = xact_latch_q;
      `MEI_ADDR_ENC_STATUS: rd_mux = {31'h0000_0000, clr_flag_q};
      `MEI_ADDR_AXIS_CTRL:  rd_mux = {30'h0000_0000, freewheel_q};
      `MEI_ADDR_STST_TIME:  rd_mux = {8'h00, stst_time_q};
      `MEI_ADDR_AXIS_STAT:  rd_mux = {28'h000_0000, src_abn, cur_scale_zero,
                                      bemf_active, standstill};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  // bus answer; unmapped addresses end with pslverr and read as zero
  // prdata keeps its last value between accesses, so it toggles less
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= acc_phase & ~pready;
      if (acc_phase & ~pready) begin
        pslverr <= ~reg_hit(paddr);
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // quadrature or full-step decoder; external channels bypass the filter
  mei_quad_dec #(
    .FILT_DIV0   (FILT_DIV0),
    .FILT_DIV1   (FILT_DIV1),
    .FILT_DIV2   (FILT_DIV2),
    .FILT_DIV3   (FILT_DIV3)
  ) u_quad (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .in_a        (src_abn ? enc_a : bemf_cmp_a), // R01
    .in_b        (src_abn ? enc_b : bemf_cmp_b),
    .filt_bypass (src_abn),
    .filt_sel    (cfg_q[`MEI_F_FILT_HI:`MEI_F_FILT_LO]), // R09
    .cnt_up      (cnt_up),
    .cnt_dn      (cnt_dn)
  );

  // index qualification against the polarity gate
  wire n_gate   = (enc_a == cfg_q[`MEI_F_POL_A]) & (enc_b == cfg_q[`MEI_F_POL_B]); // R17

  // index acts on its rising edge only, so a held-high line fires once
  wire n_evt    = src_abn & enc_n & ~n_q & n_gate;

  // an action flag enables, the clear bit picks clear or snapshot; the count latch sees every event
  wire n_action = n_evt & (clr_cont | clr_once); // R15
  wire n_clear  = n_action & clr_enc; // R18
  wire n_latch  = n_action & ~clr_enc; // R14

  // steps only count while the selected source is live
  wire count_en = src_abn | bemf_active; // R20
  wire do_step  = count_en & (cnt_up | cnt_dn);

  // next position is formed every cycle and taken only on a step
  wire [47:0] next_pos = step_pos({x_enc_q, enc_frac_q}, enc_const_q, cnt_dn, dec_mode);

  // index line one cycle late; resets to its idle low level
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      n_q <= 1'b0;
    else
      n_q <= enc_n;
  end

  // configuration; the single-shot flag clears itself after acting
  // a configuration write wins over the self-clear in the same cycle
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_q       <= `MEI_RST_ENCODER_MODE_CONFIG; // R01
      enc_const_q <= `MEI_RST_ENC_CONST;
      freewheel_q <= `MEI_RST_FREEWHEEL;
      stst_time_q <= STST_DEFAULT; // R08
    end else begin
      if (wr_cfg)
        cfg_q <= pwdata & `MEI_ENCODER_MODE_CONFIG_MASK;
      else if (n_action & clr_once)
        cfg_q[`MEI_F_CLR_ONCE] <= 1'b0; // R15
      if (wr_const)
        enc_const_q <= pwdata; // R13
      if (wr_ctrl)
        freewheel_q <= pwdata[1:0];
      if (wr_stst)
        stst_time_q <= pwdata[23:0];
    end
  end

  // position counter: index clear beats a preset, a preset beats a step
  // a preset also drops the fraction, so the written value is exact
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      x_enc_q    <= 32'h0000_0000;
      enc_frac_q <= 16'h0000;
    end else if (n_clear) begin
      x_enc_q    <= 32'h0000_0000; // R18
      enc_frac_q <= 16'h0000;
    end else if (wr_xenc) begin
      x_enc_q    <= pwdata; // R10
      enc_frac_q <= 16'h0000;
    end else if (do_step) begin
      x_enc_q    <= next_pos[47:16]; // R11
      enc_frac_q <= next_pos[15:0];
    end
  end

  // index snapshots
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      enc_latch_q  <= 32'h0000_0000;
      xact_latch_q <= 32'h0000_0000;
    end else begin
      if (n_evt)
        enc_latch_q <= x_enc_q; // R16
      if (n_latch)
        xact_latch_q <= x_actual; // R14
    end
  end

  // clear event flag: a new event wins over a write-one-to-clear
  // the diagnostic pin follows the flag one cycle later
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clr_flag_q             <= 1'b0;
      diagnostic_output_zero <= 1'b0;
    end else begin
      clr_flag_q <= n_clear | (clr_flag_q & ~(wr_status & pwdata[0])); // R19
      diagnostic_output_zero <= cfg_q[`MEI_F_DIAG_INT] & clr_flag_q; // R19
    end
  end

  // standstill: cycles since the last step reach the programmed time
  // the counter saturates, so a long idle axis never wraps to moving
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stst_cnt_q <= 24'h00_0000;
      standstill <= 1'b0;
    end else if (motor_step) begin
      stst_cnt_q <= 24'h00_0000;
      standstill <= 1'b0;
    end else begin
      if (stst_cnt_q < stst_time_q)
        stst_cnt_q <= stst_cnt_q + 24'h00_0001;
      standstill <= (stst_cnt_q >= stst_time_q); // R08
    end
  end

  // standstill back-EMF decoding needs a disabled bridge with no coil current left
  wire fw_ok = (freewheel_q == `MEI_FW_FREE) | (freewheel_q == `MEI_FW_BRAKE); // R02
  wire stst_ok = standstill & fw_ok & cur_scale_zero; // R03 R04
  wire qsc_ok = quiescence_mode & cfg_q[`MEI_F_QSC_EN]; // R05
  wire bemf_allow = ~src_abn & (stst_ok | qsc_ok);

  // a zero blank field lets decoding start one cycle after allow
  wire [31:0] blank_target = {24'h00_0000, blank_fld} * BLANK_UNIT;

  // blanking lets residual coil current decay before it looks like motion
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      blank_cnt_q <= 32'h0000_0000;
      bemf_active <= 1'b0;
    end else if (!bemf_allow) begin
      blank_cnt_q <= 32'h0000_0000;
      bemf_active <= 1'b0;
    end else begin
      if (blank_cnt_q < blank_target)
        blank_cnt_q <= blank_cnt_q + 32'h0000_0001; // R06
      bemf_active <= (blank_cnt_q >= blank_target); // R06
    end
  end

endmodule

`default_nettype wire

// ### verilog/mei_defs.vh
`ifndef MEI_DEFS_VH
`define MEI_DEFS_VH

// register byte offsets
`define MEI_ADDR_ENCODER_MODE_CONFIG    12'h000
`define MEI_ADDR_ENC_CONST  12'h004
`define MEI_ADDR_X_ENC      12'h008
`define MEI_ADDR_ENC_LATCH  12'h00C
`define MEI_ADDR_XACT_LATCH 12'h010
`define MEI_ADDR_ENC_STATUS 12'h014
`define MEI_ADDR_AXIS_CTRL  12'h018
`define MEI_ADDR_STST_TIME  12'h01C
`define MEI_ADDR_AXIS_STAT  12'h020

// encoder mode configuration fields
`define MEI_F_SRC      0
`define MEI_F_POL_A    1
`define MEI_F_POL_B    2
`define MEI_F_CLR_CONT 3
`define MEI_F_CLR_ONCE 4
`define MEI_F_CLR_ENC  5
`define MEI_F_DECIMAL  6
`define MEI_F_QSC_EN   7
`define MEI_F_HYST_LO  8
`define MEI_F_HYST_HI  10
`define MEI_F_FILT_LO  11
`define MEI_F_FILT_HI  12
`define MEI_F_DIAG_INT 13
`define MEI_F_BLANK_LO 16
`define MEI_F_BLANK_HI 23
`define MEI_ENCODER_MODE_CONFIG_MASK 32'h00FF_3FFF

// reset values
`define MEI_RST_ENCODER_MODE_CONFIG   32'h0000_0000
`define MEI_RST_ENC_CONST 32'h0001_0000
`define MEI_RST_FREEWHEEL 2'h0
`define MEI_STST_DEFAULT  24'h10_0000

// freewheel option codes
`define MEI_FW_FREE  2'h1
`define MEI_FW_BRAKE 2'h2

// timing counts in clock cycles
`define MEI_BLANK_UNIT 32'h0000_4000
`define MEI_FILT_DIV0  15'h6018
`define MEI_FILT_DIV1  15'h300C
`define MEI_FILT_DIV2  15'h1806
`define MEI_FILT_DIV3  15'h0B36

// decimal fraction base
`define MEI_DEC_BASE 17'h0_2710

`endif

// ### verilog/mei_quad_dec.v
`timescale 1ns/1ns
`default_nettype none
`include "mei_defs.vh"

module mei_quad_dec #(
  parameter [14:0] FILT_DIV0 = `MEI_FILT_DIV0,
  parameter [14:0] FILT_DIV1 = `MEI_FILT_DIV1,
  parameter [14:0] FILT_DIV2 = `MEI_FILT_DIV2,
  parameter [14:0] FILT_DIV3 = `MEI_FILT_DIV3
) (
  // clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // raw channels
  input  wire       in_a,
  input  wire       in_b,
  input  wire       filt_bypass,
  input  wire [1:0] filt_sel,
  // decoded steps
  output reg        cnt_up,
  output reg        cnt_dn
);

  reg [14:0] div_q;
  reg [1:0]  samp_q;
  reg [1:0]  filt_q;
  reg [1:0]  prev_q;
  reg        byp_q;
  reg        byp2_q;

  // next quadrature state when a leads b: 00 -> 10 -> 11 -> 01 -> 00
  function [1:0] quad_next;
    input [1:0] ab;
    begin
      case (ab)
        2'h0:    quad_next = 2'h2;
        2'h2:    quad_next = 2'h3;
        2'h3:    quad_next = 2'h1;
        default: quad_next = 2'h0;
      endcase
    end
  endfunction

  function [14:0] div_pick;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    div_pick = FILT_DIV0;
        2'h1:    div_pick = FILT_DIV1;
        2'h2:    div_pick = FILT_DIV2;
        default: div_pick = FILT_DIV3;
      endcase
    end
  endfunction

  wire tick = (div_q >= div_pick(filt_sel) - 15'h0001);

  // sample every divider tick, accept a level only when two samples agree
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q  <= 15'h0000;
      samp_q <= 2'h0;
      filt_q <= 2'h0;
    end else if (filt_bypass) begin
      div_q  <= 15'h0000;
      samp_q <= {in_a, in_b};
      filt_q <= {in_a, in_b};
    end else if (tick) begin
      div_q  <= 15'h0000;
      samp_q <= {in_a, in_b};
      if (samp_q == {in_a, in_b})
        filt_q <= samp_q; // R09
    end else begin
      div_q <= div_q + 15'h0001;
    end
  end

  // a source switch holds counting off until prev_q has seen the new source
  wire src_same = (byp_q == filt_bypass) && (byp2_q == byp_q);

  // direction from phase order; a source switch reloads without counting
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_q <= 2'h0;
      byp_q  <= 1'b0;
      byp2_q <= 1'b0;
      cnt_up <= 1'b0;
      cnt_dn <= 1'b0;
    end else begin
      prev_q <= filt_q;
      byp_q  <= filt_bypass;
      byp2_q <= byp_q;
      cnt_up <= src_same && (filt_q == quad_next(prev_q)); // R21
      cnt_dn <= src_same && (prev_q == quad_next(filt_q)); // R21
    end
  end

endmodule

`default_nettype wire

// ### verif/mei_chk.sv
`timescale 1ns/1ns
`default_nettype none
module mei_chk (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // axis state
  input wire logic        enc_n,
  input wire logic        motor_step,
  input wire logic        quiescence_mode,
  input wire logic [2:0]  bemf_threshold_select,
  input wire logic        bemf_active,
  input wire logic        standstill,
  input wire logic        diagnostic_output_zero
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // one wait state, then a single answer cycle
  sequence s_answer;
    !pready ##1 pready ##1 !pready;
  endsequence
  // completed write, the only cause for a threshold change
  wire wr_done = psel && penable && pready && pwrite;
  rdy_wait_a: assert property ($rose(penable) && psel |-> s_answer)
    else $error("bus answer timing wrong");
  map_err_a: assert property (pready && (paddr > 12'h020 || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("unmapped access not refused");
  map_ok_a: assert property (pready && paddr <= 12'h020 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  stst_hold_a: assert property (motor_step |=> !standstill [*8])
    else $error("standstill while stepping");
  bemf_gate_a: assert property (!standstill && !quiescence_mode |=> !bemf_active)
    else $error("decoder active while moving");
  blank_gap_a: assert property ($rose(standstill) |-> !bemf_active)
    else $error("decoder active without blanking");
  diag_set_a: assert property ($rose(diagnostic_output_zero) |->
    $past(enc_n, 2) || $past(wr_done, 2))
    else $error("interrupt without index");
  diag_clr_a: assert property ($fell(diagnostic_output_zero) |-> $past(wr_done, 2))
    else $error("interrupt dropped without write");
  thr_hold_a: assert property (!$past(wr_done) |-> $stable(bemf_threshold_select))
    else $error("threshold changed without write");
endmodule
bind mei_encoder_if mei_chk u_chk (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .enc_n(enc_n), .motor_step(motor_step), .quiescence_mode(quiescence_mode),
  .bemf_threshold_select(bemf_threshold_select), .bemf_active(bemf_active),
  .standstill(standstill), .diagnostic_output_zero(diagnostic_output_zero)
);
`default_nettype wire

// ### verif/mei_enc_model.sv
`timescale 1ns/1ns
`default_nettype none
module mei_enc_model (
  // clock
  input  wire logic sys_clk,
  // external encoder
  output var  logic enc_a,
  output var  logic enc_b,
  output var  logic enc_n,
  // coil comparators
  output var  logic cmp_a,
  output var  logic cmp_b
);
  logic [1:0] ph [2];
  // all lines start idle low
  initial begin
    ph[0] = 2'h0;
    ph[1] = 2'h0;
    {enc_a, enc_b, enc_n, cmp_a, cmp_b} = 5'h00;
  end
  // one edge; up walks 00,10,11,01 so A leads B
  task automatic step(input logic up, input logic coil);
    begin
      @(posedge sys_clk);
      ph[coil] = up ? ph[coil] + 2'h1 : ph[coil] - 2'h1;
      if (coil) begin
        cmp_a <= ^ph[1];
        cmp_b <= ph[1][1];
      end else begin
        enc_a <= ^ph[0];
        enc_b <= ph[0][1];
      end
      // coil edges held past the slowest filter
      repeat (coil ? 20 : 4) @(posedge sys_clk);
    end
  endtask
  // index pulse of two cycles at the present A/B levels
  task automatic index;
    begin
      @(posedge sys_clk);
      enc_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      enc_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

// ### verif/test_mei_encoder_if.sv
`timescale 1ns/1ns
`default_nettype none
`include "mei_defs.vh"
module test_mei_encoder_if;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, x_actual = 32'h0000_0000;
  logic        motor_step = 1'b0, cur_scale_zero = 1'b0, quiescence_mode = 1'b0;
  wire  [31:0] prdata;
  wire  [2:0]  thr;
  wire         pready, pslverr, bemf_active, standstill, diag;
  wire         enc_a, enc_b, enc_n, cmp_a, cmp_b;
  logic [31:0] rd;
  logic        serr;
  int          err_total = 0, n_compared = 0, pos, i, k, n;
  // short counts keep the run brief
  mei_encoder_if #(.BLANK_UNIT(32'h0000_0004),
    .FILT_DIV0(15'h0004), .FILT_DIV1(15'h0003), .FILT_DIV2(15'h0002),
    .FILT_DIV3(15'h0002)) dut (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bemf_cmp_a(cmp_a), .bemf_cmp_b(cmp_b),
    .enc_a(enc_a), .enc_b(enc_b), .enc_n(enc_n), .motor_step(motor_step),
    .x_actual(x_actual), .cur_scale_zero(cur_scale_zero),
    .quiescence_mode(quiescence_mode), .bemf_threshold_select(thr),
    .bemf_active(bemf_active), .standstill(standstill),
    .diagnostic_output_zero(diag));
  mei_enc_model enc (.sys_clk(sys_clk), .enc_a(enc_a), .enc_b(enc_b),
    .enc_n(enc_n), .cmp_a(cmp_a), .cmp_b(cmp_b));
  always #25 sys_clk = ~sys_clk;
  task automatic finish_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_compared++;
      if (got !== exp) begin
        err_total++;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // setup, access until pready, release on that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int w;
    begin
      @(posedge sys_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      w = 0;
      do begin
        @(posedge sys_clk);
        w++;
      end while (pready !== 1'b1 && w < 10);
      rd = prdata;
      serr = pslverr;
      {psel, penable} <= 2'b00;
      if (w >= 10) begin
        err_total++;
        finish_test();
      end
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
    end
  endtask
  // hang guard, far beyond the normal run
  initial begin
    #4000000;
    err_total++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(`MEI_ADDR_ENCODER_MODE_CONFIG, 32'h0000_0000);
    rdc(`MEI_ADDR_ENC_CONST, 32'h0001_0000);
    rdc(`MEI_ADDR_ENC_LATCH, 32'h0000_0000);
    rdc(`MEI_ADDR_STST_TIME, 32'h0010_0000);
    rdc(12'h024, 32'h0000_0000);
    chk({31'h0, serr}, 32'h0000_0001);
    rdc(12'h006, 32'h0000_0000);
    chk({31'h0, serr}, 32'h0000_0001);
    // quadrature lines ignored until selected
    apb(1'b1, `MEI_ADDR_X_ENC, 32'h0000_0064);
    enc.step(1'b1, 1'b0);
    rdc(`MEI_ADDR_X_ENC, 32'h0000_0064);
    apb(1'b1, `MEI_ADDR_ENCODER_MODE_CONFIG, 32'h0000_0001);
    pos = 100;
    for (i = 0; i < 6; i++) begin
      enc.step(i < 4, 1'b0);
      pos += (i < 4) ? 1 : -1;
      rdc(`MEI_ADDR_X_ENC, pos);
    end
    apb(1'b1, `MEI_ADDR_ENC_CONST, 32'hFFFF_0000);
    enc.step(1'b1, 1'b0);
    rdc(`MEI_ADDR_X_ENC, pos - 1);
    // decimal 25.6 twice, then -25.6 three times
    apb(1'b1, `MEI_ADDR_ENCODER_MODE_CONFIG, 32'h0000_0041);
    apb(1'b1, `MEI_ADDR_X_ENC, 32'h0000_0000);
    apb(1'b1, `MEI_ADDR_ENC_CONST, 32'h0019_1770);
    for (i = 0; i < 5; i++) begin
      if (i == 2)
        apb(1'b1, `MEI_ADDR_ENC_CONST, {16'h0000 - 16'd26, 16'd10000 - 16'd6000});
      enc.step(1'b1, 1'b0);
      rdc(`MEI_ADDR_X_ENC, (i == 0) ? 25 : (i == 1) ? 51 : (i == 2) ? 25 : (i == 3) ? 0 : -26);
    end
    // single shot clear, gated on A and B both high
    apb(1'b1, `MEI_ADDR_ENC_CONST, 32'h0001_0000);
    apb(1'b1, `MEI_ADDR_ENCODER_MODE_CONFIG, 32'h0000_2037);
    apb(1'b1, `MEI_ADDR_X_ENC, 32'h0000_0010);
    pos = 16;
    for (i = 0; i < 4 && !(enc_a === 1'b0 && enc_b === 1'b1); i++) begin
      enc.step(1'b1, 1'b0);
      pos++;
    end
    enc.index();
    rdc(`MEI_ADDR_ENC_LATCH, 32'h0000_0000);
    enc.step(1'b0, 1'b0);
    enc.index();
    chk({31'h0, diag}, 32'h0000_0001);
    rdc(`MEI_ADDR_ENC_LATCH, pos - 1);
    rdc(`MEI_ADDR_X_ENC, 32'h0000_0000);
    rdc(`MEI_ADDR_ENC_STATUS, 32'h0000_0001);
    rdc(`MEI_ADDR_ENCODER_MODE_CONFIG, 32'h0000_2027);
    for (i = 0; i < 4; i++)
      enc.step(1'b1, 1'b0);
    enc.index();
    rdc(`MEI_ADDR_X_ENC, 32'h0000_0004);
    rdc(`MEI_ADDR_ENC_LATCH, 32'h0000_0004);
    apb(1'b1, `MEI_ADDR_ENC_STATUS, 32'h0000_0001);
    rdc(`MEI_ADDR_ENC_STATUS, 32'h0000_0000);
    chk({31'h0, diag}, 32'h0000_0000);
    // continuous: latch twice, then clear
    pos = 4;
    for (k = 0; k < 3; k++) begin
      apb(1'b1, `MEI_ADDR_ENCODER_MODE_CONFIG, (k == 2) ? 32'h0000_002F : 32'h0000_000F);
      x_actual <= 32'h0000_1000 + k;
      for (i = 0; i < 4; i++)
        enc.step(1'b1, 1'b0);
      pos = (k == 2) ? 0 : pos + 4;
      enc.index();
      if (k < 2)
        rdc(`MEI_ADDR_XACT_LATCH, 32'h0000_1000 + k);
      rdc(`MEI_ADDR_X_ENC, pos);
    end
    // coil decoder: current gone, bridge off, one full step is 256
    cur_scale_zero <= 1'b1;
    apb(1'b1, `MEI_ADDR_STST_TIME, 32'h0000_0010);
    apb(1'b1, `MEI_ADDR_ENC_CONST, 32'h0100_0000);
    apb(1'b1, `MEI_ADDR_ENCODER_MODE_CONFIG, 32'h0002_0000);
    for (k = 0; k < 3; k++) begin
      apb(1'b1, `MEI_ADDR_AXIS_CTRL, k);
      motor_step <= 1'b1;
      @(posedge sys_clk);
      motor_step <= 1'b0;
      @(posedge sys_clk);
      for (n = 0; n < 40 && standstill !== 1'b1; n++)
        @(posedge sys_clk);
      chk(n >= 15 && n <= 20, 32'h0000_0001);
      for (i = 0; i < 20 && bemf_active !== 1'b1; i++)
        @(posedge sys_clk);
      chk({31'h0, bemf_active}, k != 0);
      chk(k == 0 || (i >= 8 && i <= 10), 32'h0000_0001);
      enc.step(1'b1, 1'b1);
      pos += (k != 0) ? 256 : 0;
      rdc(`MEI_ADDR_X_ENC, pos);
    end
    for (k = 0; k < 8; k++) begin
      apb(1'b1, `MEI_ADDR_ENCODER_MODE_CONFIG, 32'h0002_0000 | (k << 8) | ((k & 3) << 11));
      @(posedge sys_clk);
      chk({29'h0, thr}, k);
      enc.step(k % 2, 1'b1);
      pos += (k % 2) ? 256 : -256;
      rdc(`MEI_ADDR_X_ENC, pos);
    end
    // quiescence keeps the decoder alive only for source zero
    apb(1'b1, `MEI_ADDR_AXIS_CTRL, 32'h0000_0000);
    quiescence_mode <= 1'b1;
    apb(1'b1, `MEI_ADDR_ENCODER_MODE_CONFIG, 32'h0002_0080);
    for (i = 0; i < 20 && bemf_active !== 1'b1; i++)
      @(posedge sys_clk);
    chk({31'h0, bemf_active}, 32'h0000_0001);
    apb(1'b1, `MEI_ADDR_ENCODER_MODE_CONFIG, 32'h0002_0081);
    rdc(`MEI_ADDR_AXIS_STAT, {28'h0, 4'b1101});
    finish_test();
  end
endmodule
`default_nettype wire
